// ==== pkg/gbps_link_pkg.sv ====
// Shared constants for the serial sample and control link.
// Assumes one 200 MHz clock per end; the line is modelled slowly.
//
// Summary of operation
// - Scramble nibbles with 8-bit generator state
// - Pair 4-bit words into 8-bit words
// - Serialize each 8-bit word onto line
// - Even nibble low, odd nibble high
// - Scramble after ID and checksum insertion
// - Epoch tick always lands on even word
// - Generator reloads preset at every tick
// - Six control channels merged in one stage
// - Control bit 7 constant one for alignment
// - Control bit 6 carries inverted preamble
// - Command, status on their own bits 4 and 5
// - Dump, command, status align to control marker
// - Checksum skips two sample bits
// - 4-bit samples or paired 7-bit samples
// - Sign bit 3; 7-bit sign bit 2
// - Code 0101 invalid, 1000 means five
// - 7-bit high nibble bit 3 flags validity
// - Unused slots filled with 1010 pattern
// - Idle stream still generated with fill
// - Receiver recovers nibble order from byte halves
// - Epoch tick is the common alignment reference
// - Receiver applies new seed at tick
package gbps_link_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 200;
  // Modelled line bit time
  localparam int LINE_BIT_NS = 40;
  // Cycles per half bit
  localparam int HALF_CYC = (LINE_BIT_NS * CLK_MHZ / 1000) / 2;
  // Good words before the receiver locks
  localparam int LOCK_WORDS = 4;

  // ****************************************
  // Generator
  // ****************************************
  localparam logic [7:0] PRN_TAPS = 8'hB8;
  // Generator state after reset
  localparam logic [7:0] PRN_RST = 8'h01;
  // Idle preamble bit pattern
  localparam logic [7:0] IDLE_PREAMBLE = 8'h55;

  // ****************************************
  // Sample codes
  // ****************************************
  localparam logic [3:0] FILL_NIB = 4'hA;
  localparam logic [3:0] INVALID_NIB = 4'h5;
  localparam logic [3:0] FIVE_CODE = 4'h8;
  localparam logic [6:0] FIVE_VALUE = 7'h05;
  localparam int SIGN4_BIT = 3;
  localparam int SIGN7_BIT = 2;
  localparam int VALID7_BIT = 3;

  // ****************************************
  // Control word bit positions
  // ****************************************
  localparam int CB_TIME_REF = 0;
  localparam int CB_PHASE_MODEL = 1;
  localparam int CB_PHASE_ERROR = 2;
  localparam int CB_DUMP = 3;
  localparam int CB_COMMAND = 4;
  localparam int CB_STATUS = 5;
  localparam int CB_INV_PRE = 6;
  localparam int CB_MARK = 7;

  // Generator advance, one step per nibble
  function automatic logic [7:0] prn_step(input logic [7:0] s);
    return {s[6:0], ^(s & PRN_TAPS)};
  endfunction

  // Four-bit fold of the two halves used as the XOR mask
  function automatic logic [3:0] prn_mask(input logic [7:0] s);
    return s[3:0] ^ s[7:4];
  endfunction

  // Receiver alignment states
  typedef enum logic [1:0] {
    RX_HUNT = 2'b00,
    RX_LOCK = 2'b01
  } rx_state_t;

endpackage

// ==== pkg/gbps_link_if.sv ====
// Link between the two ends: forwarded clock and two data lines.
// Assumes both ends run on their own clk_i and sample these signals.
`timescale 1ns/1ps
interface gbps_link_if;
  // Forwarded bit clock, made by the transmitter
  logic link_clk;
  // Scrambled sample stream
  logic sample_line;
  // Merged control stream
  logic ctrl_line;

  // Transmitting end
  modport tx (
    output link_clk,
    output sample_line,
    output ctrl_line
  );

  // Receiving end
  modport rx (
    input link_clk,
    input sample_line,
    input ctrl_line
  );
endinterface

// ==== src/gbps_link_tx.sv ====
// Transmitting end: sample scrambler, pairing and serializer,
// plus the control stream multiplexer.
// Assumes sample words already carry identifiers and checksum.
`timescale 1ns/1ps
module gbps_link_tx #(
  parameter int HALF = gbps_link_pkg::HALF_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Sample word stream
  input wire logic [3:0] sample_i,
  input wire logic sample_tick_i,
  input wire logic sample_valid_i,
  output logic sample_ready_o,
  // Generator preset
  input wire logic [7:0] seed_i,
  // Control channels, one bit each per word
  input wire logic [5:0] ctrl_i,
  output logic ctrl_take_o,
  // Line side
  gbps_link_if.tx link
);

  // ****************************************
  // Bit clock divider
  // ****************************************

  // Divider terminal count
  localparam logic [7:0] HALF_M1 = 8'(HALF - 1);

  // Divider count
  logic [7:0] div_q;
  // Forwarded clock level
  logic link_clk_q;
  // Half bit enable
  wire logic half_en = (div_q == HALF_M1);
  // Falling edge of the forwarded clock
  wire logic fall_en = half_en & link_clk_q;

  // Divider and forwarded clock
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_q <= 8'h00;
      link_clk_q <= 1'b0;
    end else if (half_en) begin
      div_q <= 8'h00;
      link_clk_q <= ~link_clk_q;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // ****************************************
  // Two entry input buffer
  // ****************************************

  // Entries hold tick flag and nibble
  logic [4:0] mem_q [2];
  // Fill level
  logic [1:0] cnt_q;
  // Ready to the source
  logic ready_q;
  // Serial bit index
  logic [2:0] bit_q;

  // Word load at the last bit of a word
  wire logic load_en = fall_en & (bit_q == 3'h7);
  // Entry presence
  wire logic have0 = (cnt_q != 2'h0);
  wire logic have1 = (cnt_q == 2'h2);
  // Even slot takes the head entry when present
  wire logic take_even = load_en & have0;
  // Odd slot never takes a tick entry, so the tick stays even
  wire logic take_odd = load_en & have1 & ~mem_q[1][4];
  // Entries removed this cycle
  wire logic [1:0] pop_n = {1'b0, take_even} + {1'b0, take_odd};
  // Entries kept after removal
  wire logic [1:0] rem_n = cnt_q - pop_n;
  // Accepted input word
  wire logic push = sample_valid_i & ready_q;
  // Next fill level
  wire logic [1:0] cnt_d = rem_n + {1'b0, push};

  // Shift or write each entry
  for (genvar gi = 0; gi < 2; gi++) begin : g_buf
    // Source entry after removal
    wire logic [1:0] src = 2'(gi) + pop_n;
    // Entry keeps a shifted word
    wire logic keep = (src < cnt_q);
    // Entry takes the new word
    wire logic fill = push & (2'(gi) == rem_n);

    // Entry register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        mem_q[gi] <= 5'h00;
      end else if (keep) begin
        mem_q[gi] <= mem_q[src[0]];
      end else if (fill) begin
        mem_q[gi] <= {sample_tick_i, sample_i};
      end
    end
  end

  // Fill level and ready; ready drops only when both entries hold
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 2'h0;
      ready_q <= 1'b1;
    end else begin
      cnt_q <= cnt_d;
      ready_q <= (cnt_d != 2'h2);
    end
  end

  // ****************************************
  // Word assembly and scrambler
  // ****************************************

  // Generator state
  logic [7:0] prn_q;
  // Idle preamble rotation
  logic [7:0] pre_q;

  // Missing words become fill, so the stream never stops
  wire logic [3:0] even_w = have0 ? mem_q[0][3:0] : gbps_link_pkg::FILL_NIB;
  wire logic [3:0] odd_w = (have1 & ~mem_q[1][4]) ?
    mem_q[1][3:0] : gbps_link_pkg::FILL_NIB;
  // Tick on the even slot
  wire logic even_tick = have0 & mem_q[0][4];
  // Preset on tick, otherwise continue
  wire logic [7:0] s0 = even_tick ? seed_i : prn_q;
  wire logic [7:0] s1 = gbps_link_pkg::prn_step(s0);
  // Each nibble XORed with its own mask
  wire logic [3:0] even_s = even_w ^ gbps_link_pkg::prn_mask(s0);
  wire logic [3:0] odd_s = odd_w ^ gbps_link_pkg::prn_mask(s1);
  // Even nibble in the low half of the byte
  wire logic [7:0] word_s = {odd_s, even_s};
  // Control byte: marker, inverted preamble, six channels
  wire logic [7:0] word_c = {1'b1, ~pre_q[0], ctrl_i};

  // Generator steps twice and preamble rotates once per word
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prn_q <= gbps_link_pkg::PRN_RST;
      pre_q <= gbps_link_pkg::IDLE_PREAMBLE;
    end else if (load_en) begin
      prn_q <= gbps_link_pkg::prn_step(s1);
      pre_q <= {pre_q[0], pre_q[7:1]};
    end
  end

  // ****************************************
  // Serializers
  // ****************************************

  // Remaining bits of the current words
  logic [7:0] sh_s_q;
  logic [7:0] sh_c_q;
  // Line levels
  logic sample_line_q;
  logic ctrl_line_q;
  // Control channel take pulse
  logic take_q;

  // Both lines shift together, low bit first, on the falling edge
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bit_q <= 3'h7;
      sh_s_q <= 8'h00;
      sh_c_q <= 8'h00;
      sample_line_q <= 1'b0;
      ctrl_line_q <= 1'b0;
    end else if (load_en) begin
      // New word pair; command and status load with the other channels
      bit_q <= 3'h0;
      sample_line_q <= word_s[0];
      sh_s_q <= {1'b0, word_s[7:1]};
      ctrl_line_q <= word_c[0];
      sh_c_q <= {1'b0, word_c[7:1]};
    end else if (fall_en) begin
      // Next bit of the same words
      bit_q <= bit_q + 3'h1;
      sample_line_q <= sh_s_q[0];
      sh_s_q <= {1'b0, sh_s_q[7:1]};
      ctrl_line_q <= sh_c_q[0];
      sh_c_q <= {1'b0, sh_c_q[7:1]};
    end
  end

  // Tells the user the control bits were taken
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      take_q <= 1'b0;
    end else begin
      take_q <= load_en;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign sample_ready_o = ready_q;
  assign ctrl_take_o = take_q;
  assign link.link_clk = link_clk_q;
  assign link.sample_line = sample_line_q;
  assign link.ctrl_line = ctrl_line_q;

endmodule

// ==== src/gbps_link_rx.sv ====
// Receiving end: bit alignment on the control marker, descrambler,
// sample decoding and a two entry output buffer.
// Assumes user logic decodes the epoch from the time channel.
`timescale 1ns/1ps
module gbps_link_rx (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Line side
  gbps_link_if.rx link,
  // Seed, epoch mark and sample format
  input wire logic [7:0] seed_i,
  input wire logic epoch_i,
  input wire logic mode7_i,
  // Control channels per word
  output logic word_o,
  output logic [5:0] ctrl_o,
  output logic locked_o,
  output logic overrun_o,
  // Decoded nibble stream
  output logic [3:0] out_nib_o,
  output logic out_even_o,
  output logic out_epoch_o,
  output logic [6:0] out_sample_o,
  output logic out_ok_o,
  output logic out_full_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [2:0] ck_q;
  logic [1:0] sl_q;
  logic [1:0] cl_q;

  // Two flops per pin, a third for clock edges
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ck_q <= 3'h0;
      sl_q <= 2'h0;
      cl_q <= 2'h0;
    end else begin
      ck_q <= {ck_q[1:0], link.link_clk};
      sl_q <= {sl_q[0], link.sample_line};
      cl_q <= {cl_q[0], link.ctrl_line};
    end
  end

  // Rising edge of the forwarded clock
  wire logic rise = ck_q[1] & ~ck_q[2];

  // ****************************************
  // Deserializer and alignment
  // ****************************************
  logic [7:0] sh_s_q;
  logic [7:0] sh_c_q;
  logic [2:0] cnt_q;
  logic [2:0] good_q;
  gbps_link_pkg::rx_state_t st_q;
  logic word_q;
  logic [5:0] ctrl_q;
  logic [7:0] raw_q;

  // Word completes on this bit
  wire logic done = rise & (cnt_q == 3'h7);
  wire logic [7:0] cw = {cl_q[1], sh_c_q[7:1]};
  wire logic [7:0] sw = {sl_q[1], sh_s_q[7:1]};
  wire logic mark_ok = cw[gbps_link_pkg::CB_MARK];
  wire logic locked = (st_q == gbps_link_pkg::RX_LOCK);
  localparam logic [2:0] LOCK_M1 = 3'(gbps_link_pkg::LOCK_WORDS - 1);

  // Bad marker slips one bit and restarts the search
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sh_s_q <= 8'h00;
      sh_c_q <= 8'h00;
      cnt_q <= 3'h0;
      good_q <= 3'h0;
      st_q <= gbps_link_pkg::RX_HUNT;
    end else if (rise) begin
      sh_s_q <= sw;
      sh_c_q <= cw;
      if (done && !mark_ok) begin
        cnt_q <= 3'h7;
        good_q <= 3'h0;
        st_q <= gbps_link_pkg::RX_HUNT;
      end else begin
        cnt_q <= cnt_q + 3'h1;
        if (done && good_q != LOCK_M1) begin
          good_q <= good_q + 3'h1;
        end else if (done) begin
          st_q <= gbps_link_pkg::RX_LOCK;
        end
      end
    end
  end

  // Completed words once locked
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      word_q <= 1'b0;
      ctrl_q <= 6'h00;
      raw_q <= 8'h00;
    end else begin
      word_q <= done & mark_ok & locked;
      if (done && mark_ok && locked) begin
        ctrl_q <= cw[5:0];
        raw_q <= sw;
      end
    end
  end

  // ****************************************
  // Descrambler
  // ****************************************
  logic [7:0] prn_q;
  logic [7:0] nib_q;
  logic [1:0] pend_q;
  logic ep_q;
  logic ovr_q;
  logic [3:0] lo_q;

  // Same preset, steps and mask as the transmitter
  wire logic [7:0] s0 = epoch_i ? seed_i : prn_q;
  wire logic [7:0] s1 = gbps_link_pkg::prn_step(s0);
  wire logic [3:0] ev_d = raw_q[3:0] ^ gbps_link_pkg::prn_mask(s0);
  wire logic [3:0] od_d = raw_q[7:4] ^ gbps_link_pkg::prn_mask(s1);

  // ****************************************
  // Decoding and buffer
  // ****************************************
  logic [14:0] mem_q [2];
  logic [1:0] cnt_q2;
  logic vld_q;

  // Even nibble first, as placed by the transmitter
  // Pending 2'b11 means the even nibble is next, 2'b01 the odd one
  wire logic is_even = pend_q[1];
  wire logic [3:0] nib = is_even ? nib_q[3:0] : nib_q[7:4];
  // No push while a new word replaces the pending pair
  wire logic push = (pend_q != 2'h0) & (cnt_q2 != 2'h2) & ~word_q;
  // Four bit: 0101 invalid, 1000 stands for five
  wire logic ok4 = (nib != gbps_link_pkg::INVALID_NIB);
  wire logic [6:0] v4 = (nib == gbps_link_pkg::FIVE_CODE) ? gbps_link_pkg::FIVE_VALUE :
    {{3{nib[gbps_link_pkg::SIGN4_BIT]}}, nib};
  // Seven bit: even low nibble, odd high nibble with valid bit
  wire logic [6:0] v7 = {nib[gbps_link_pkg::SIGN7_BIT:0], lo_q};
  wire logic ok7 = ~is_even & nib[gbps_link_pkg::VALID7_BIT];
  wire logic full = ~mode7_i | ~is_even;
  wire logic [14:0] ent = {full, mode7_i ? ok7 : ok4, mode7_i ? v7 : v4,
    ep_q & is_even, is_even, nib};
  wire logic pop = vld_q & out_ready_i;
  wire logic [1:0] rem_n = cnt_q2 - {1'b0, pop};
  wire logic [1:0] cnt_d = rem_n + {1'b0, push};

  // Descramble a word; the next word while pending is an overrun
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prn_q <= gbps_link_pkg::PRN_RST;
      nib_q <= 8'h00;
      pend_q <= 2'h0;
      ep_q <= 1'b0;
      ovr_q <= 1'b0;
      lo_q <= 4'h0;
    end else if (word_q) begin
      prn_q <= gbps_link_pkg::prn_step(s1);
      nib_q <= {od_d, ev_d};
      pend_q <= 2'h3;
      ep_q <= epoch_i;
      ovr_q <= ovr_q | (pend_q != 2'h0);
    end else if (push) begin
      pend_q <= {1'b0, pend_q[1]};
      if (is_even) begin
        lo_q <= nib;
      end
    end
  end

  // Shift or write each entry
  for (genvar gi = 0; gi < 2; gi++) begin : g_buf
    wire logic [1:0] src = 2'(gi) + {1'b0, pop};
    wire logic keep = (src < cnt_q2);
    wire logic fill = push & (2'(gi) == rem_n);

    // Entry register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        mem_q[gi] <= 15'h0000;
      end else if (keep) begin
        mem_q[gi] <= mem_q[src[0]];
      end else if (fill) begin
        mem_q[gi] <= ent;
      end
    end
  end

  // Fill level and output valid
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q2 <= 2'h0;
      vld_q <= 1'b0;
    end else begin
      cnt_q2 <= cnt_d;
      vld_q <= (cnt_d != 2'h0);
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign word_o = word_q;
  assign ctrl_o = ctrl_q;
  assign locked_o = (st_q == gbps_link_pkg::RX_LOCK);
  assign overrun_o = ovr_q;
  assign out_full_o = mem_q[0][14];
  assign out_ok_o = mem_q[0][13];
  assign out_sample_o = mem_q[0][12:6];
  assign out_epoch_o = mem_q[0][5];
  assign out_even_o = mem_q[0][4];
  assign out_nib_o = mem_q[0][3:0];
  assign out_valid_o = vld_q;

endmodule

// ==== tb/gbps_link_assertions.sv ====
// Concurrent checks on the link lines and the handshakes beside them.
// Assumes both ends share clk_i and rst_n_i; HALF matches the transmitter.
`timescale 1ns/1ps
module gbps_link_assertions #(
  parameter int HALF = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Link lines
  input wire logic link_clk,
  input wire logic sample_line,
  input wire logic ctrl_line,
  // End ports watched
  input wire logic ctrl_take_o,
  input wire logic word_o,
  input wire logic out_valid_o,
  input wire logic out_ready_i,
  input wire logic [3:0] out_nib_o,
  input wire logic out_even_o
);
  // ****************************************
  // Helper logic
  // ****************************************
  localparam int WORD_CYC = 16 * HALF;
  logic lclk_q; // Link clock one cycle ago
  logic seen_q; // A link clock change was seen
  logic fell_q; // A falling link clock edge was seen
  logic take_seen_q; // A control take was seen
  logic last_even_q; // Slot of the last popped nibble
  logic [2:0] bit_q; // Bit index on the line, first fall gives 0
  logic [7:0] half_q; // Cycles since the last link clock change
  logic [7:0] take_q; // Cycles since the last control take
  wire chg = link_clk != lclk_q;
  wire rise = link_clk && !lclk_q;
  wire fall = lclk_q && !link_clk;
  wire pop = out_valid_o && out_ready_i;

  // Edge history and spacing counters
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {lclk_q, seen_q, fell_q, take_seen_q, last_even_q} <= 5'h00;
      {bit_q, half_q, take_q} <= {3'h7, 8'h00, 8'h00};
    end else begin
      lclk_q <= link_clk;
      seen_q <= seen_q || chg;
      fell_q <= fell_q || fall;
      take_seen_q <= take_seen_q || ctrl_take_o;
      last_even_q <= pop ? out_even_o : last_even_q;
      bit_q <= fall ? bit_q + 3'h1 : bit_q;
      half_q <= chg ? 8'h00 : half_q + 8'h01;
      take_q <= ctrl_take_o ? 8'h00 : take_q + 8'h01;
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  clk_half_a: assert property (chg && seen_q |-> half_q == 8'(HALF - 1))
    else $error("link clock half period wrong");
  sample_edge_a: assert property ($changed(sample_line) |-> $fell(link_clk))
    else $error("sample line moved off the falling clock");
  ctrl_edge_a: assert property ($changed(ctrl_line) |-> fall)
    else $error("control line moved off the falling clock");
  marker_bit_a: assert property (rise && fell_q && bit_q == 3'h7 |-> ctrl_line)
    else $error("control marker bit not one");
  take_space_a: assert property (ctrl_take_o && take_seen_q |-> take_q == 8'(WORD_CYC - 1))
    else $error("control take spacing wrong");
  take_pulse_a: assert property (ctrl_take_o |=> !ctrl_take_o)
    else $error("control take longer than one cycle");
  word_pulse_a: assert property (word_o |=> !word_o)
    else $error("word strobe longer than one cycle");
  stall_hold_a: assert property (out_valid_o && !out_ready_i |=>
    out_valid_o && $stable(out_nib_o) && $stable(out_even_o))
    else $error("head entry changed during stall");
  even_odd_a: assert property (pop |-> out_even_o != last_even_q)
    else $error("even and odd slots out of turn");
  cover property (pop && out_even_o);
  cover property (out_valid_o && !out_ready_i ##1 pop);
  cover property (word_o);
endmodule

// ==== tb/tb_gbps_chopper_mux_framing.sv ====
// Self-checking bench: both ends joined by one link, fed end to end.
// Assumes the design package, interface and both ends compile first.
`timescale 1ns/1ps
module tb_gbps_chopper_mux_framing;
  // ****************************************
  // Signals
  // ****************************************
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] sample_i = 4'h0;
  logic sample_tick_i = 1'b0;
  logic sample_valid_i = 1'b0;
  logic [7:0] seed_i = 8'h00; // Same preset at both ends
  logic [5:0] ctrl_i = 6'h00;
  logic mode7_i = 1'b0;
  logic out_ready_i = 1'b0;
  logic sample_ready_o, ctrl_take_o, word_o, locked_o, overrun_o;
  logic out_even_o, out_epoch_o, out_ok_o, out_full_o, out_valid_o;
  logic [5:0] ctrl_o;
  logic [3:0] out_nib_o;
  logic [6:0] out_sample_o;
  wire epoch_i = ctrl_o[0]; // Epoch decoded from the time channel
  int fails = 0;
  int n_compared = 0;
  logic [31:0] rnd = 32'h03D9;
  logic [5:0] exp_q[$]; // {mode7, tick, nibble} per sent nibble
  logic [5:0] ctl_q[$]; // Channel bits per sent word
  logic started = 1'b0;
  logic cstart = 1'b0;
  logic ev = 1'b1;
  logic [3:0] last_lo = 4'h0;
  logic [5:0] stall = 6'h00;

  gbps_link_if link ();
  gbps_link_tx #(.HALF(gbps_link_pkg::HALF_CYC)) gbps_link_tx_i (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .sample_i(sample_i), .sample_tick_i(sample_tick_i),
    .sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o), .seed_i(seed_i),
    .ctrl_i(ctrl_i), .ctrl_take_o(ctrl_take_o), .link(link));
  gbps_link_rx gbps_link_rx_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(link),
    .seed_i(seed_i), .epoch_i(epoch_i), .mode7_i(mode7_i), .word_o(word_o),
    .ctrl_o(ctrl_o), .locked_o(locked_o), .overrun_o(overrun_o), .out_nib_o(out_nib_o),
    .out_even_o(out_even_o), .out_epoch_o(out_epoch_o), .out_sample_o(out_sample_o),
    .out_ok_o(out_ok_o), .out_full_o(out_full_o), .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i));
  gbps_link_assertions #(.HALF(gbps_link_pkg::HALF_CYC)) gbps_link_assertions_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .link_clk(link.link_clk),
    .sample_line(link.sample_line), .ctrl_line(link.ctrl_line), .ctrl_take_o(ctrl_take_o),
    .word_o(word_o), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i),
    .out_nib_o(out_nib_o), .out_even_o(out_even_o));

  // 200 MHz clock
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic cmp_flag(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic cmp_entry(input logic [14:0] got, input logic [14:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: entry %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_ctrl(input logic [5:0] got, input logic [5:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: channels %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Reset for 16 cycles, looking at outputs halfway
  task automatic do_reset;
    @(negedge clk_i);
    rst_n_i = 1'b0;
    repeat (8) @(negedge clk_i);
    cmp_flag(sample_ready_o, 1'b1);
    cmp_flag(locked_o, 1'b0);
    cmp_flag(out_valid_o, 1'b0);
    cmp_flag(link.ctrl_line | link.link_clk, 1'b0);
    repeat (8) @(negedge clk_i);
    rst_n_i = 1'b1;
  endtask

  // Offer one nibble and hold it until taken
  task automatic send_nib(input logic [3:0] n, input logic t);
    int k;
    sample_i = n;
    sample_tick_i = t;
    sample_valid_i = 1'b1;
    k = 0;
    while (sample_ready_o !== 1'b1 && k < 200) begin
      @(negedge clk_i);
      k++;
    end
    @(negedge clk_i);
  endtask

  // One format: lock, 14 words with two epochs, then drain
  task automatic run_phase(input logic m7);
    int w;
    int k;
    logic t;
    logic [3:0] ev_n;
    logic [3:0] od_n;
    mode7_i = m7;
    seed_i = rnd[7:0];
    // Quiet channels while hunting, so only the marker is a steady one
    ctrl_i = 6'h00;
    do_reset();
    k = 0;
    while (locked_o !== 1'b1 && k < 4000) begin
      @(negedge clk_i);
      k++;
    end
    cmp_flag(locked_o, 1'b1);
    for (w = 0; w < 14; w++) begin
      k = 0;
      while (ctrl_take_o !== 1'b1 && k < 200) begin
        @(negedge clk_i);
        k++;
      end
      rnd = lfsr(lfsr(lfsr(rnd)));
      t = (w == 2) || (w == 8);
      // New preset for the second epoch, at both ends
      if (w == 8) begin
        seed_i = rnd[15:8];
      end
      ctrl_i = {rnd[20:16], t};
      ev_n = (!m7 && w == 4) ? gbps_link_pkg::INVALID_NIB : rnd[3:0];
      od_n = (!m7 && w == 4) ? gbps_link_pkg::FIVE_CODE : rnd[7:4];
      send_nib(ev_n, t);
      send_nib(od_n, 1'b0);
      if (w >= 2) begin
        exp_q.push_back({m7, t, ev_n});
        exp_q.push_back({m7, 1'b0, od_n});
        ctl_q.push_back(ctrl_i);
      end
      sample_valid_i = 1'b0;
      @(negedge clk_i);
      cmp_flag(sample_ready_o, 1'b0);
      // Offer refused while the buffer is full
      sample_valid_i = 1'b1;
      sample_i = 4'hF;
      repeat (3) @(negedge clk_i);
      sample_valid_i = 1'b0;
    end
    k = 0;
    while ((exp_q.size() != 0 || ctl_q.size() != 0) && k < 1000) begin
      @(negedge clk_i);
      k++;
    end
    cmp_flag(exp_q.size() == 0 && ctl_q.size() == 0, 1'b1);
    cmp_flag(overrun_o, 1'b0);
  endtask

  // Work out one entry from the nibble sent and compare
  task automatic check_entry(input logic [5:0] e);
    logic [3:0] n;
    logic full;
    logic ok;
    logic [6:0] s;
    n = e[3:0];
    full = e[5] ? !ev : 1'b1;
    s = (n == gbps_link_pkg::FIVE_CODE) ? gbps_link_pkg::FIVE_VALUE : {{3{n[3]}}, n};
    s = e[5] ? {n[2:0], last_lo} : s;
    ok = e[5] ? n[3] : (n != gbps_link_pkg::INVALID_NIB);
    cmp_entry({out_nib_o, out_even_o, out_epoch_o, out_full_o,
      out_full_o ? {out_ok_o, out_sample_o} : 8'h00},
      {n, ev, e[4], full, full ? {ok, s} : 8'h00});
    last_lo = ev ? n : last_lo;
    ev = !ev;
  endtask

  // ****************************************
  // Processes
  // ****************************************
  // Receiver stalls 16 of every 64 cycles
  always @(negedge clk_i) begin
    stall <= stall + 6'h01;
    out_ready_i <= stall[5:4] != 2'b00;
  end

  // Watch both result kinds, oldest note first
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      started = 1'b0;
      cstart = 1'b0;
    end else begin
      if (word_o === 1'b1) begin
        cstart = cstart || (ctrl_o[0] === 1'b1);
        if (cstart && ctl_q.size() > 0) begin
          cmp_ctrl(ctrl_o, ctl_q.pop_front());
        end
      end
      if (out_valid_o === 1'b1 && out_ready_i) begin
        if (out_epoch_o === 1'b1) begin
          started = 1'b1;
          ev = 1'b1;
        end
        if (started && exp_q.size() > 0) begin
          check_entry(exp_q.pop_front());
        end
      end
    end
  end

  // Watchdog
  initial begin
    repeat (30000) @(posedge clk_i);
    fails++;
    $display("mismatch at %0t: watchdog expired", $time);
    wrap_up();
  end

  // Main sequence: 4-bit format, then 7-bit format after a second reset
  initial begin
    run_phase(1'b0);
    run_phase(1'b1);
    wrap_up();
  end
endmodule
